// File: logic/svsc_top.sv
// Serial port, gain update and mute control of the stereo volume block
`timescale 1ns/1ns
`include "svsc_defs.svh"
module svsc_top #(
	parameter int POR_CYC = `SVSC_POR_CYC,
	parameter int TMO_CYC = `SVSC_ZC_TMO_CYC,
	parameter int CAL_CYC = `SVSC_CAL_CYC
) (
	input  wire logic          CLOCK,
	input  wire logic          RESET_N,
	input  wire logic          SCLK,
	input  wire logic          CS_N,
	input  wire logic          SERIAL_IN,
	output logic               SERIAL_OUT,
	output logic               SERIAL_OUT_OE,
	input  wire logic          ZERO_CROSS_ENABLE,
	input  wire logic          MUTE_N,
	input  wire logic          UNDERVOLTAGE,
	input  wire logic          RIGHT_ZC,
	input  wire logic          LEFT_ZC,
	output svsc_pkg::svsc_gains_s GAIN,
	output logic               RIGHT_ANALOG_GROUND,
	output logic               LEFT_ANALOG_GROUND,
	output logic               HW_MUTE,
	output logic               CAL_START
);
	import svsc_pkg::*;

	// Link domain: shift register on serial clock, no reset there
	logic [15:0] shift_q;
	logic        sout_q;
	logic [15:0] frame_q;
	logic        frame_tgl_q;

	// Bits enter MSB first, so the right byte ends in the top half
	always_ff @(posedge SCLK) begin
		if (!CS_N) begin
			shift_q <= {shift_q[14:0], SERIAL_IN};
		end
	end

	// Outgoing bit moves on the falling edge for the next device
	always_ff @(negedge SCLK) begin
		sout_q <= shift_q[`SVSC_FRAME_BITS-1];
	end

	// Chip select rising ends the frame; CS itself clocks the capture,
	// since the serial clock may stand still once the frame is over
	// Reset clears the toggle so the core never sees an unknown edge
	always_ff @(posedge CS_N or negedge RESET_N) begin
		if (!RESET_N) begin
			frame_q     <= 16'h0000;
			frame_tgl_q <= 1'b0;
		end else begin
			frame_q     <= shift_q;
			frame_tgl_q <= ~frame_tgl_q;
		end
	end

	// Output enable follows chip select, synchronised to the core clock
	logic [1:0] cs_sync_q;
	logic [2:0] tgl_sync_q;
	logic [1:0] mute_sync_q;
	logic [1:0] uv_sync_q;
	logic [1:0] zen_sync_q;
	logic [1:0] rzc_sync_q;
	logic [1:0] lzc_sync_q;

	// Two-stage synchronisers for everything from pins or the link
	always_ff @(posedge CLOCK) begin
		cs_sync_q   <= {cs_sync_q[0], CS_N};
		tgl_sync_q  <= {tgl_sync_q[1:0], frame_tgl_q};
		mute_sync_q <= {mute_sync_q[0], MUTE_N};
		uv_sync_q   <= {uv_sync_q[0], UNDERVOLTAGE};
		zen_sync_q  <= {zen_sync_q[0], ZERO_CROSS_ENABLE};
		rzc_sync_q  <= {rzc_sync_q[0], RIGHT_ZC};
		lzc_sync_q  <= {lzc_sync_q[0], LEFT_ZC};
	end

	wire frame_evt = tgl_sync_q[2] ^ tgl_sync_q[1];
	wire mute_act  = ~mute_sync_q[1];
	wire uv_act    = uv_sync_q[1];
	wire zc_en     = zen_sync_q[1];

	// Core state
	svsc_state_e state_q, state_d;
	logic [31:0] por_cnt_q;
	logic [31:0] cal_cnt_q;
	logic        mute_prev_q;
	logic        rzc_prev_q;
	logic        lzc_prev_q;
	logic        pend_r_q;
	logic        pend_l_q;
	logic [31:0] tmo_r_q;
	logic [31:0] tmo_l_q;
	logic [31:0] tmo_m_q;
	svsc_gain_t  new_r_q;
	svsc_gain_t  new_l_q;
	svsc_gains_s gain_q;
	logic        hw_mute_q;
	logic        cal_q;
	logic        oe_q;
	logic        rag_q;
	logic        lag_q;

	wire rzc_rise = rzc_sync_q[1] & ~rzc_prev_q;
	wire lzc_rise = lzc_sync_q[1] & ~lzc_prev_q;
	wire mute_fall = mute_act & ~mute_prev_q;
	wire por_done = (por_cnt_q >= 32'(POR_CYC - 1));
	wire cal_done = (cal_cnt_q >= 32'(CAL_CYC - 1));
	wire run      = (state_q == SVSC_RUN);
	wire frm_r    = run & frame_evt & (frame_q[15:8] != gain_q.right);
	wire frm_l    = run & frame_evt & (frame_q[7:0] != gain_q.left);
	// Ungated when enable low; gated waits for crossing or timeout
	wire app_r    = pend_r_q & (~zc_en | rzc_rise |
		(tmo_r_q >= 32'(TMO_CYC - 1)));
	wire app_l    = pend_l_q & (~zc_en | lzc_rise |
		(tmo_l_q >= 32'(TMO_CYC - 1)));
	// Mute engages on any crossing regardless of enable, else timeout
	wire mute_go  = mute_act & (rzc_rise | lzc_rise |
		(tmo_m_q >= 32'(TMO_CYC - 1)));

	// Power-up, calibration and undervoltage sequencing
	always_comb begin
		state_d = state_q;
		case (state_q)
			SVSC_POR: if (por_done) state_d = SVSC_CAL;
			SVSC_CAL: if (cal_done) state_d = SVSC_RUN;
			SVSC_RUN: if (uv_act) state_d = SVSC_UV;
			SVSC_UV:  if (!uv_act) state_d = SVSC_POR;
			default:  state_d = SVSC_POR;
		endcase
		if (uv_act) begin
			state_d = SVSC_UV;
		end
	end

	// Sequencer counters
	always_ff @(posedge CLOCK) begin
		if (!RESET_N) begin
			state_q   <= SVSC_POR;
			por_cnt_q <= 32'h0;
			cal_cnt_q <= 32'h0;
		end else begin
			state_q   <= state_d;
			por_cnt_q <= (state_q == SVSC_POR) ? por_cnt_q + 32'h1 : 32'h0;
			cal_cnt_q <= (state_q == SVSC_CAL) ? cal_cnt_q + 32'h1 : 32'h0;
		end
	end

	// Gain pending and apply, each channel on its own
	always_ff @(posedge CLOCK) begin
		if (!RESET_N || !run) begin
			gain_q   <= '{`SVSC_GAIN_MUTE, `SVSC_GAIN_MUTE};
			rag_q    <= 1'b1;
			lag_q    <= 1'b1;
			pend_r_q <= 1'b0;
			pend_l_q <= 1'b0;
			new_r_q  <= `SVSC_GAIN_MUTE;
			new_l_q  <= `SVSC_GAIN_MUTE;
			tmo_r_q  <= 32'h0;
			tmo_l_q  <= 32'h0;
		end else begin
			if (frm_r) begin
				new_r_q  <= frame_q[`SVSC_RIGHT_MSB -: 8];
				pend_r_q <= 1'b1;
				tmo_r_q  <= 32'h0;
			end else if (app_r) begin
				gain_q.right <= new_r_q;
				// Ground flag moves with the gain, so the pin stays a flop
				rag_q        <= (new_r_q == `SVSC_GAIN_MUTE);
				pend_r_q     <= 1'b0;
			end else if (pend_r_q) begin
				tmo_r_q <= tmo_r_q + 32'h1;
			end
			if (frm_l) begin
				new_l_q  <= frame_q[`SVSC_LEFT_MSB -: 8];
				pend_l_q <= 1'b1;
				tmo_l_q  <= 32'h0;
			end else if (app_l) begin
				gain_q.left <= new_l_q;
				lag_q       <= (new_l_q == `SVSC_GAIN_MUTE);
				pend_l_q    <= 1'b0;
			end else if (pend_l_q) begin
				tmo_l_q <= tmo_l_q + 32'h1;
			end
		end
	end

	// Hardware mute and calibration starts
	always_ff @(posedge CLOCK) begin
		if (!RESET_N) begin
			hw_mute_q   <= 1'b1;
			cal_q       <= 1'b0;
			tmo_m_q     <= 32'h0;
			mute_prev_q <= 1'b0;
			rzc_prev_q  <= 1'b0;
			lzc_prev_q  <= 1'b0;
			oe_q        <= 1'b0;
		end else begin
			mute_prev_q <= mute_act;
			rzc_prev_q  <= rzc_sync_q[1];
			lzc_prev_q  <= lzc_sync_q[1];
			oe_q        <= ~cs_sync_q[1];
			// Calibration pulse at power-up end and each mute assertion while running
			cal_q <= (state_q == SVSC_POR && por_done) ||
				(run && mute_fall);
			tmo_m_q <= (mute_act && !hw_mute_q) ? tmo_m_q + 32'h1 : 32'h0;
			if (!run) begin
				hw_mute_q <= 1'b1;
			end else if (!mute_act) begin
				hw_mute_q <= 1'b0;
			end else if (mute_go) begin
				hw_mute_q <= 1'b1;
			end
		end
	end

	// Registered outputs
	assign GAIN                = gain_q;
	assign HW_MUTE             = hw_mute_q;
	assign CAL_START           = cal_q;
	assign RIGHT_ANALOG_GROUND = rag_q;
	assign LEFT_ANALOG_GROUND  = lag_q;
	assign SERIAL_OUT_OE       = oe_q;
	assign SERIAL_OUT          = sout_q;
endmodule

// File: logic/svsc_defs.svh
// Constants of the stereo volume serial control block
`ifndef SVSC_DEFS_SVH
`define SVSC_DEFS_SVH
// Overview of operation
// - At power-up hold reset about 100ms in hardware mute, flip-flops cleared; the serial shift register, serial output flop and synchronisers have no reset.
// - After power-up reset ends, offset calibration starts by itself.
// - After calibration both gain bytes load 00, soft mute, until written.
// - Undervoltage gives hardware mute; recovery reruns the power-up sequence.
// - Serial input bits are taken only while chip select is low.
// - A frame is 16 bits: right gain byte then left gain byte.
// - Each gain code is sent MSB first as unsigned binary.
// - Serial input is sampled on each rising serial clock edge.
// - Serial output is high impedance while chip select is high.
// - Device is a 16-bit shift register passing bits to serial output.
// - Serial output changes after each falling serial clock edge.
// - Gain code zero mutes channel, input switched to analog ground.
// - Codes 1..255 give gain 31.5 - 0.5*(255-code) dB.
// - Zero-cross gating off while enable is low, on while high.
// - Gating acts per channel and only when its gain changes.
// - Gated change applies at positive zero crossing or after 16ms.
// - Hardware mute disconnects output buffers, adds 10k terminations.
// - Hardware mute takes effect at zero crossing or after 16ms.
// - Each hardware mute assertion starts an offset calibration.
// - Code zero sets amplifier to unity gain, input at analog ground.
`define SVSC_CLK_MHZ      100
`define SVSC_POR_MS       100
`define SVSC_POR_CYC      (`SVSC_POR_MS * 1000 * `SVSC_CLK_MHZ)
`define SVSC_ZC_TMO_MS    16
`define SVSC_ZC_TMO_CYC   (`SVSC_ZC_TMO_MS * 1000 * `SVSC_CLK_MHZ)
`define SVSC_CAL_CYC      64
`define SVSC_FRAME_BITS   16
`define SVSC_GAIN_MUTE    8'h00
`define SVSC_RIGHT_MSB    15
`define SVSC_LEFT_MSB     7
`endif

// File: logic/svsc_pkg.sv
// Types of the stereo volume serial control block
package svsc_pkg;
	typedef logic [7:0] svsc_gain_t;
	typedef struct packed {
		svsc_gain_t right;
		svsc_gain_t left;
	} svsc_gains_s;
	typedef enum logic [3:0] {
		SVSC_POR = 4'h1,
		SVSC_CAL = 4'h2,
		SVSC_RUN = 4'h4,
		SVSC_UV  = 4'h8
	} svsc_state_e;
endpackage

// File: testbench/svsc_monitor.sv
// Port checker of the stereo volume serial control block
`timescale 1ns/1ns
module svsc_monitor #(
	parameter int TMO_CYC = 40
) (
	input wire logic             CLOCK,
	input wire logic             RESET_N,
	input wire logic             CS_N,
	input wire logic             SERIAL_OUT_OE,
	input wire logic             ZERO_CROSS_ENABLE,
	input wire logic             MUTE_N,
	input wire logic             UNDERVOLTAGE,
	input wire logic             RIGHT_ZC,
	input wire logic             LEFT_ZC,
	input svsc_pkg::svsc_gains_s GAIN,
	input wire logic             RIGHT_ANALOG_GROUND,
	input wire logic             LEFT_ANALOG_GROUND,
	input wire logic             HW_MUTE,
	input wire logic             CAL_START
);
	import svsc_pkg::*;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RESET_N);
	int mute_q;
	// Cycles spent with the mute pin held low
	always_ff @(posedge CLOCK)
		mute_q <= MUTE_N ? 0 : mute_q + 1;
	// Gated change with no crossing seen yet
	sequence s_quiet;
		(ZERO_CROSS_ENABLE && !RIGHT_ZC && !LEFT_ZC && MUTE_N
			&& !UNDERVOLTAGE)[*8];
	endsequence
	property p_oe_off; CS_N[*8] |-> !SERIAL_OUT_OE; endproperty
	property p_agnd_r; RIGHT_ANALOG_GROUND == (GAIN.right == 8'h00); endproperty
	property p_agnd_l; LEFT_ANALOG_GROUND == (GAIN.left == 8'h00); endproperty
	property p_uv_mute; UNDERVOLTAGE[*5] |-> HW_MUTE; endproperty
	property p_uv_gain; UNDERVOLTAGE[*5] |-> GAIN == 16'h0000; endproperty
	property p_cal_pulse; CAL_START |=> !CAL_START; endproperty
	property p_mute_cal; $fell(MUTE_N) ##1 !MUTE_N |-> ##[0:6] CAL_START;
	endproperty
	property p_mute_tmo; mute_q == TMO_CYC + 6 |-> HW_MUTE; endproperty
	property p_gated; $rose(CS_N) ##1 s_quiet |-> GAIN == $past(GAIN, 8);
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("output enabled");
	a_agnd_r: assert property (p_agnd_r) else $error("right ground");
	a_agnd_l: assert property (p_agnd_l) else $error("left ground");
	a_uv_mute: assert property (p_uv_mute) else $error("uv mute");
	a_uv_gain: assert property (p_uv_gain) else $error("uv gain");
	a_cal_pulse: assert property (p_cal_pulse) else $error("cal pulse");
	a_mute_cal: assert property (p_mute_cal) else $error("mute cal");
	a_mute_tmo: assert property (p_mute_tmo) else $error("mute late");
	a_gated: assert property (p_gated) else $error("gain ungated");
endmodule

// File: testbench/svsc_host.sv
// Host model that drives the serial control port
`timescale 1ns/1ns
module svsc_host (
	output logic      SCLK,
	output logic      CS_N,
	output logic      SERIAL_IN,
	input  wire logic SERIAL_OUT
);
	// Link clock idles low; only the noise task pulses it between frames
	initial begin
		SCLK = 1'b0;
		CS_N = 1'b1;
		SERIAL_IN = 1'b0;
	end
	// One frame MSB first, catching the chained output on each rise
	task automatic send(input logic [15:0] w, output logic [15:0] r);
		CS_N = 1'b0;
		#60;
		for (int i = 15; i >= 0; i--) begin
			SERIAL_IN = w[i];
			#15 SCLK = 1'b1;
			r[i] = SERIAL_OUT;
			#15 SCLK = 1'b0;
		end
		#15 CS_N = 1'b1;
		SERIAL_IN = ~w[0]; // Released line shows no stale bit
	endtask
	// Clock pulses with chip select high must be ignored
	task automatic noise();
		for (int i = 0; i < 16; i++) begin
			SERIAL_IN = ~SERIAL_IN;
			#15 SCLK = 1'b1;
			#15 SCLK = 1'b0;
		end
	endtask
endmodule

// File: testbench/svsc_top_test.sv
// Self-checking bench of the stereo volume serial control block
`timescale 1ns/1ns
module svsc_top_test;
	import svsc_pkg::*;
	logic clock, reset_n, zce, mute_n, uv, rzc, lzc, so, oe, rag, lag, hwm, cal;
	wire  sclk, cs_n, sin;
	svsc_gains_s gain;
	logic [15:0] r;
	int n, failures, comparisons;
	svsc_top #(.POR_CYC(50), .TMO_CYC(40), .CAL_CYC(8)) dut (.CLOCK(clock),
		.RESET_N(reset_n), .SCLK(sclk), .CS_N(cs_n), .SERIAL_IN(sin),
		.SERIAL_OUT(so), .SERIAL_OUT_OE(oe), .ZERO_CROSS_ENABLE(zce),
		.MUTE_N(mute_n), .UNDERVOLTAGE(uv), .RIGHT_ZC(rzc), .LEFT_ZC(lzc),
		.GAIN(gain), .RIGHT_ANALOG_GROUND(rag), .LEFT_ANALOG_GROUND(lag),
		.HW_MUTE(hwm), .CAL_START(cal));
	svsc_host host (.SCLK(sclk), .CS_N(cs_n), .SERIAL_IN(sin),
		.SERIAL_OUT(so));
	// Core clock, 10 ns period
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic cycles(input int k);
		repeat (k) @(posedge clock);
	endtask
	// Bounded wait for the calibration pulse
	task automatic wait_cal(output int k);
		k = 0;
		while (cal !== 1'b1 && k < 300) begin
			@(posedge clock);
			k++;
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Watchdog against a hung wait
	initial begin
		#100000;
		failures++;
		final_report();
	end
	// Main sequence
	initial begin
		{reset_n, zce, uv, rzc, lzc} = 5'h00;
		mute_n = 1'b1;
		cycles(12);
		check(gain, 16'h0000);
		check({13'h0000, hwm, cal, oe}, 16'h0004);
		reset_n <= 1'b1;
		wait_cal(n);
		check(16'(n >= 50 && n < 100), 16'h0001);
		cycles(20);
		check({gain.right, 6'h00, rag, lag}, 16'h0003);
		host.send(16'h8001, r);
		cycles(8);
		check(gain, 16'h8001);
		check({14'h0000, rag, lag}, 16'h0000);
		host.send(16'h00FF, r);
		cycles(8);
		check(r, 16'h8001);
		check({gain.left, 6'h00, rag, lag}, 16'hFF02);
		host.noise();
		cycles(8);
		check(gain, 16'h00FF);
		zce <= 1'b1;
		host.send(16'h5A5A, r);
		cycles(8);
		check(gain, 16'h00FF);
		cycles(2);
		rzc <= 1'b1;
		cycles(8);
		check(gain, 16'h5AFF);
		cycles(45);
		check(gain, 16'h5A5A);
		{zce, rzc} <= 2'b00;
		mute_n <= 1'b0;
		wait_cal(n);
		check(16'(n < 10), 16'h0001);
		cycles(50);
		check({15'h0000, hwm}, 16'h0001);
		mute_n <= 1'b1;
		cycles(5);
		check({15'h0000, hwm}, 16'h0000);
		uv <= 1'b1;
		cycles(6);
		check({hwm, gain[14:0]}, 16'h8000);
		uv <= 1'b0;
		wait_cal(n);
		check(16'(n >= 50 && n < 100), 16'h0001);
		cycles(20);
		check({hwm, gain[14:0]}, 16'h0000);
		final_report();
	end
endmodule
bind svsc_top svsc_monitor #(.TMO_CYC(TMO_CYC)) u_mon (.CLOCK(CLOCK),
	.RESET_N(RESET_N), .CS_N(CS_N), .SERIAL_OUT_OE(SERIAL_OUT_OE),
	.ZERO_CROSS_ENABLE(ZERO_CROSS_ENABLE), .MUTE_N(MUTE_N),
	.UNDERVOLTAGE(UNDERVOLTAGE), .RIGHT_ZC(RIGHT_ZC), .LEFT_ZC(LEFT_ZC),
	.GAIN(GAIN), .RIGHT_ANALOG_GROUND(RIGHT_ANALOG_GROUND),
	.LEFT_ANALOG_GROUND(LEFT_ANALOG_GROUND), .HW_MUTE(HW_MUTE),
	.CAL_START(CAL_START));
